// ---- core/link_cfg_pkg.sv ----
// link_cfg_pkg: register map, field layout and carriers for the link
// configuration and status block of the packet switch.
// assumes: word register indices as printed, data 32 bits wide.
package link_cfg_pkg;
	// ---------------------------------------------------------------
	// register indices
	// ---------------------------------------------------------------
	localparam logic [7:0] rsv_a_idx = 8'h10;
	localparam logic [7:0] rsv_b_idx = 8'h11;
	localparam logic [7:0] dbg_src_idx = 8'h1f;
	localparam logic [7:0] lstat_base = 8'h20;
	localparam logic [7:0] lstat_last = 8'h28;
	localparam logic [7:0] pstat_base = 8'h40;
	localparam logic [7:0] pstat_last = 8'h47;
	localparam logic [7:0] lcfg_base = 8'h80;
	localparam logic [7:0] lcfg_last = 8'h88;
	localparam logic [7:0] stat_base = 8'ha0;
	localparam logic [7:0] stat_last = 8'ha7;
	localparam int n_links = 9;
	localparam int n_plinks = 8;
	localparam int n_static = 8;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int f_target_lo = 24;
	localparam int f_dest_lo = 16;
	localparam int f_dir_lo = 8;
	localparam int f_net_lo = 4;
	localparam int b_junk = 2;
	localparam int b_dst_busy = 1;
	localparam int b_src_busy = 0;
	localparam int b_enable = 31;
	localparam int b_wide = 30;
	localparam int b_err = 27;
	localparam int b_gave_cr = 26;
	localparam int b_have_cr = 25;
	localparam int b_link_greeting_token = 24;
	localparam int b_rx_rst = 23;
	localparam int f_sym_lo = 11;
	localparam int f_tok_lo = 0;
	localparam int b_st_en = 31;
	localparam int b_st_proc = 8;
	localparam int f_st_chan_lo = 0;
	localparam int b_dbg_rsv = 4;
	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [1:0] rsv_reset = 2'h0;
	localparam logic [31:0] zero_word = 32'h0000_0000;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		system_link = 2'b00,
		processor_link = 2'b01,
		switch_control_regs = 2'b10,
		target_undef = 2'b11
	} link_target_kind_t;
	typedef struct packed {
		link_target_kind_t kind;
		logic [7:0] dest;
		logic junk;
		logic dst_busy;
		logic src_busy;
	} link_state_t;
	typedef struct packed {
		logic enable;
		logic wide;
		logic [10:0] sym_gap;
		logic [10:0] tok_gap;
	} link_setup_t;
	typedef struct packed {
		logic en;
		logic proc;
		logic [4:0] chan;
	} static_fwd_t;
	typedef struct packed {
		logic err;
		logic gave_credit;
		logic have_credit;
	} link_credit_t;
endpackage

// ---- core/link_tx_pacer.sv ----
// link_tx_pacer: idle gap pacing for one external link transmitter.
// assumes: sym_sent/tok_last from same-clock link logic.
`timescale 1ns/1ps
module link_tx_pacer (
	input wire logic mclk, // system clock
	input wire logic rst, // sync reset, high
	input wire logic [10:0] sym_gap, // symbol gap minus one
	input wire logic [10:0] tok_gap, // token gap minus one
	input wire logic sym_sent, // a symbol left this cycle
	input wire logic tok_last, // that symbol ended a token
	output logic may_send // next symbol may go
);
	logic [11:0] cnt_q;
	// ---------------------------------------------------------------
	// gap counter, loads field+1 idle clocks after each symbol
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= 12'h000;
		end else if (sym_sent) begin
			cnt_q <= tok_last ? {1'b0, tok_gap} + 12'h001
				: {1'b0, sym_gap} + 12'h001;
		end else if (cnt_q != 12'h000) begin
			cnt_q <= cnt_q - 12'h001;
		end
	end
	assign may_send = (cnt_q == 12'h000);
endmodule

// ---- core/switch_link_config_status.sv ----
// switch_link_config_status: register file for link status, direction,
// network, external link setup and static forwarding of the switch.
// assumes: link state inputs on mclk; pin inputs come asynchronous.
`timescale 1ns/1ps
module switch_link_config_status (
	input wire logic mclk, // system clock, 25 MHz
	input wire logic rst, // sync reset, high
	input wire logic [7:0] addr, // register index
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [31:0] rdata, // read data, cycle after rd
	input wire logic [1:0] global_debug_event, // core_one, core_zero
	input wire link_cfg_pkg::link_state_t
		lstate [link_cfg_pkg::n_links], // link status
	input wire link_cfg_pkg::link_state_t
		pstate [link_cfg_pkg::n_plinks], // processor-link status
	input wire logic [8:0] rx_err_pin, // overflow/illegal token, async
	input wire logic [8:0] credit_in_pin, // remote gave credit, async
	input wire logic [8:0] credit_out, // we issued credit to remote
	input wire logic [8:0] sym_req, // transmit wants a symbol
	input wire logic [8:0] sym_last, // that symbol ends a token
	input wire logic [15:0] pkt_mismatch, // node id xor destination
	input wire logic pkt_valid, // mismatch is valid
	output logic [8:0] link_en, // link owns the pins
	output logic [8:0] link_wide, // five-wire mode
	output logic [8:0] sym_go, // symbol may be sent
	output logic [8:0] link_greeting_token_send, // send greeting, pulse
	output logic [8:0] rx_reset, // receiver reset, pulse
	output logic [8:0] route_hit, // packet leaves on link
	output link_cfg_pkg::static_fwd_t
		fwd [link_cfg_pkg::n_static] // static forwarding, by link A..H
);
	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	logic [1:0] rsv_a_q, rsv_b_q;
	logic [1:0] dbg_src_q;
	logic dbg_rsv_q;
	logic [3:0] dir_q [link_cfg_pkg::n_links];
	logic [1:0] net_q [link_cfg_pkg::n_links];
	logic [1:0] pnet_q [link_cfg_pkg::n_plinks];
	link_cfg_pkg::link_setup_t setup_q [link_cfg_pkg::n_links];
	link_cfg_pkg::link_credit_t cr_q [link_cfg_pkg::n_links];
	link_cfg_pkg::static_fwd_t st_q [link_cfg_pkg::n_static];
	logic [8:0] err_s1_q, err_s2_q, cin_s1_q, cin_s2_q;
	logic [8:0] link_greeting_token_q, rxrst_q, sym_go_q, route_q;
	logic [31:0] rdata_q;
	logic [3:0] route_dir_q;
	logic route_ok_q;
	logic [8:0] may_send;

	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------
	function automatic logic [3:0] top_bit(input logic [15:0] v);
		top_bit = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (v[i]) begin
				top_bit = 4'(i);
			end
		end
	endfunction

	// static slot index for link letter A..H: slots are C,D,A,B,G,H,E,F
	function automatic int slot_of(input int letter);
		slot_of = letter ^ 2;
	endfunction

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			err_s1_q <= 9'h000;
			err_s2_q <= 9'h000;
			cin_s1_q <= 9'h000;
			cin_s2_q <= 9'h000;
		end else begin
			err_s1_q <= rx_err_pin;
			err_s2_q <= err_s1_q;
			cin_s1_q <= credit_in_pin;
			cin_s2_q <= cin_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// reserved and debug source registers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			rsv_a_q <= link_cfg_pkg::rsv_reset;
			rsv_b_q <= link_cfg_pkg::rsv_reset;
		end else if (wr && addr == link_cfg_pkg::rsv_a_idx) begin
			rsv_a_q <= wdata[1:0];
		end else if (wr && addr == link_cfg_pkg::rsv_b_idx) begin
			rsv_b_q <= wdata[1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			dbg_src_q <= 2'h0;
			dbg_rsv_q <= 1'b0;
		end else begin
			if (global_debug_event != 2'h0) begin
				dbg_src_q <= global_debug_event;
			end else if (wr && addr == link_cfg_pkg::dbg_src_idx) begin
				dbg_src_q <= wdata[1:0];
			end
			if (wr && addr == link_cfg_pkg::dbg_src_idx) begin
				dbg_rsv_q <= wdata[link_cfg_pkg::b_dbg_rsv];
			end
		end
	end

	// ---------------------------------------------------------------
	// per external link: direction, network, setup, credit
	// ---------------------------------------------------------------
	generate
		for (genvar g = 0; g < link_cfg_pkg::n_links; g++) begin : g_link
			logic sel_s, sel_c;
			assign sel_s = wr && addr == link_cfg_pkg::lstat_base + 8'(g);
			assign sel_c = wr && addr == link_cfg_pkg::lcfg_base + 8'(g);

			always_ff @(posedge mclk) begin
				if (rst) begin
					dir_q[g] <= 4'h0;
					net_q[g] <= 2'h0;
				end else if (sel_s) begin
					dir_q[g] <= wdata[11:8];
					net_q[g] <= wdata[5:4];
				end
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					setup_q[g] <= '0;
				end else if (sel_c) begin
					setup_q[g].enable <= wdata[link_cfg_pkg::b_enable];
					setup_q[g].wide <= wdata[link_cfg_pkg::b_wide];
					setup_q[g].sym_gap <= wdata[21:11];
					setup_q[g].tok_gap <= wdata[10:0];
				end
			end

			// link_greeting_token/receiver reset are write-one pulses
			always_ff @(posedge mclk) begin
				if (rst) begin
					link_greeting_token_q[g] <= 1'b0;
					rxrst_q[g] <= 1'b0;
				end else begin
					link_greeting_token_q[g] <= sel_c && wdata[link_cfg_pkg::b_link_greeting_token];
					rxrst_q[g] <= sel_c && wdata[link_cfg_pkg::b_rx_rst];
				end
			end

			// credit: set by remote wins over our own clear
			always_ff @(posedge mclk) begin
				if (rst) begin
					cr_q[g] <= '0;
				end else begin
					cr_q[g].gave_credit <= credit_out[g];
					if (cin_s2_q[g]) begin
						cr_q[g].have_credit <= 1'b1;
					end else if (sel_c && wdata[link_cfg_pkg::b_link_greeting_token]) begin
						cr_q[g].have_credit <= 1'b0;
					end
					if (err_s2_q[g]) begin
						cr_q[g].err <= 1'b1;
					end else if (sel_c && wdata[link_cfg_pkg::b_rx_rst]) begin
						cr_q[g].err <= 1'b0;
					end
				end
			end

			link_tx_pacer u_pacer (
				.mclk(mclk),
				.rst(rst),
				.sym_gap(setup_q[g].sym_gap),
				.tok_gap(setup_q[g].tok_gap),
				.sym_sent(sym_go_q[g]),
				.tok_last(sym_last[g]),
				.may_send(may_send[g])
			);

			always_ff @(posedge mclk) begin
				if (rst) begin
					sym_go_q[g] <= 1'b0;
				end else begin
					sym_go_q[g] <= sym_req[g] && may_send[g] && !sym_go_q[g]
						&& setup_q[g].enable && cr_q[g].have_credit;
				end
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					route_q[g] <= 1'b0;
				end else begin
					route_q[g] <= route_ok_q && dir_q[g] == route_dir_q;
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// routing direction lookup, direction of top mismatching bit
	// ---------------------------------------------------------------
	logic [3:0] dir_tab_q [16];
	always_ff @(posedge mclk) begin
		if (rst) begin
			route_dir_q <= 4'h0;
			route_ok_q <= 1'b0;
		end else begin
			route_dir_q <= dir_tab_q[top_bit(pkt_mismatch)];
			route_ok_q <= pkt_valid && pkt_mismatch != 16'h0000;
		end
	end

	// table of directions, one per mismatch dimension, fixed to index
	generate
		for (genvar d = 0; d < 16; d++) begin : g_dim
			assign dir_tab_q[d] = 4'(d);
		end
	endgenerate

	// ---------------------------------------------------------------
	// processor-link network and static forwarding
	// ---------------------------------------------------------------
	generate
		for (genvar p = 0; p < link_cfg_pkg::n_plinks; p++) begin : g_pl
			always_ff @(posedge mclk) begin
				if (rst) begin
					pnet_q[p] <= 2'h0;
				end else if (wr && addr == link_cfg_pkg::pstat_base + 8'(p)) begin
					pnet_q[p] <= wdata[5:4];
				end
			end
		end
		for (genvar s = 0; s < link_cfg_pkg::n_static; s++) begin : g_st
			always_ff @(posedge mclk) begin
				if (rst) begin
					st_q[s] <= '0;
				end else if (wr && addr == link_cfg_pkg::stat_base + 8'(s)) begin
					st_q[s].en <= wdata[link_cfg_pkg::b_st_en];
					st_q[s].proc <= wdata[link_cfg_pkg::b_st_proc];
					st_q[s].chan <= wdata[4:0];
				end
			end
			// output by link letter A..H from slot order C,D,A,B,G,H,E,F
			always_ff @(posedge mclk) begin
				if (rst) begin
					fwd[s] <= '0;
				end else begin
					fwd[s] <= st_q[slot_of(s)];
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			link_en <= 9'h000;
			link_wide <= 9'h000;
		end else begin
			for (int i = 0; i < link_cfg_pkg::n_links; i++) begin
				link_en[i] <= setup_q[i].enable;
				link_wide[i] <= setup_q[i].wide;
			end
		end
	end
	assign link_greeting_token_send = link_greeting_token_q;
	assign rx_reset = rxrst_q;
	assign sym_go = sym_go_q;
	assign route_hit = route_q;

	// ---------------------------------------------------------------
	// read path, unmapped and reserved bits read zero, except reserved bit 4 of dbg_src_idx (dbg_rsv_q), which reads back
	// ---------------------------------------------------------------
	function automatic logic [31:0] status_word(
		input link_cfg_pkg::link_state_t s);
		status_word = link_cfg_pkg::zero_word;
		status_word[25:24] = s.kind;
		status_word[23:16] = s.dest;
		status_word[link_cfg_pkg::b_junk] = s.junk;
		status_word[link_cfg_pkg::b_dst_busy] = s.dst_busy;
		status_word[link_cfg_pkg::b_src_busy] = s.src_busy;
	endfunction

	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= link_cfg_pkg::zero_word;
		end else if (rd) begin
			rdata_q <= link_cfg_pkg::zero_word;
			if (addr == link_cfg_pkg::rsv_a_idx) begin
				rdata_q[1:0] <= rsv_a_q;
			end else if (addr == link_cfg_pkg::rsv_b_idx) begin
				rdata_q[1:0] <= rsv_b_q;
			end else if (addr == link_cfg_pkg::dbg_src_idx) begin
				rdata_q[1:0] <= dbg_src_q;
				rdata_q[link_cfg_pkg::b_dbg_rsv] <= dbg_rsv_q;
			end
			for (int i = 0; i < link_cfg_pkg::n_links; i++) begin
				if (addr == link_cfg_pkg::lstat_base + 8'(i)) begin
					rdata_q <= status_word(lstate[i]) | {20'h0,
						dir_q[i], 2'h0, net_q[i], 4'h0};
				end
				if (addr == link_cfg_pkg::lcfg_base + 8'(i)) begin
					rdata_q <= {setup_q[i].enable, setup_q[i].wide, 2'h0,
						cr_q[i].err, cr_q[i].gave_credit,
						cr_q[i].have_credit, 3'h0,
						setup_q[i].sym_gap, setup_q[i].tok_gap};
				end
			end
			for (int i = 0; i < link_cfg_pkg::n_plinks; i++) begin
				if (addr == link_cfg_pkg::pstat_base + 8'(i)) begin
					rdata_q <= status_word(pstate[i]) | {26'h0,
						pnet_q[i], 4'h0};
				end
			end
			for (int i = 0; i < link_cfg_pkg::n_static; i++) begin
				if (addr == link_cfg_pkg::stat_base + 8'(i)) begin
					rdata_q <= {st_q[i].en, 22'h0, st_q[i].proc, 3'h0,
						st_q[i].chan};
				end
			end
		end else begin
			rdata_q <= link_cfg_pkg::zero_word;
		end
	end
	assign rdata = rdata_q;
endmodule

// ---- test/link_cfg_checker.sv ----
// link_cfg_checker: port assertions of the link configuration block.
// assumes: bound into switch_link_config_status, one clock mclk.
`timescale 1ns/1ps
module link_cfg_checker (
	input wire logic mclk, // system clock
	input wire logic rst, // sync reset
	input wire logic [7:0] addr, // register index
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	input wire logic [31:0] rdata, // read data
	input wire logic [8:0] link_en, // link owns pins
	input wire logic [8:0] sym_go, // symbol grant
	input wire logic [8:0] sym_last, // token end
	input wire logic [8:0] link_greeting_token_send, // greeting pulse
	input wire logic [8:0] rx_reset // receiver reset pulse
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic cfg0, last_q, seen_q;
	logic [10:0] sgap_q, tgap_q, need_w;
	logic [11:0] idle_q;
	assign cfg0 = wr && addr == 8'h80;
	assign need_w = last_q ? tgap_q : sgap_q;
	// ----
	// gap mirror of link 0
	// ----
	always_ff @(posedge mclk) begin
		if (rst) begin
			sgap_q <= 11'h000;
			tgap_q <= 11'h000;
		end else if (cfg0) begin
			sgap_q <= wdata[21:11];
			tgap_q <= wdata[10:0];
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			idle_q <= 12'h000;
			seen_q <= 1'b0;
			last_q <= 1'b0;
		end else if (sym_go[0]) begin
			idle_q <= 12'h000;
			seen_q <= 1'b1;
			last_q <= sym_last[0];
		end else if (idle_q != 12'hfff) begin
			idle_q <= idle_q + 12'h001;
		end
	end
	// ----
	// properties
	// ----
	property p_idle_rd; !$past(rd) |-> rdata == 32'h0; endproperty
	property p_rsv_rd; rd && addr[7:1] == 7'h08 |=> rdata[31:2] == 30'h0;
	endproperty
	property p_ls_rd; rd && addr >= 8'h20 && addr <= 8'h28 |=>
		rdata[31:26] == 6'h0 && rdata[15:12] == 4'h0 && rdata[7:6] == 2'h0
		&& !rdata[3]; endproperty
	property p_ps_rd; rd && addr[7:3] == 5'h08 |=>
		rdata[31:26] == 6'h0 && rdata[15:6] == 10'h0 && !rdata[3];
	endproperty
	property p_en; cfg0 |-> ##2 link_en[0] == $past(wdata[31], 2);
	endproperty
	property p_link_greeting_token; link_greeting_token_send[0] == $past(cfg0 && wdata[24]); endproperty
	property p_rxr; rx_reset[0] == $past(cfg0 && wdata[23]); endproperty
	property p_gap; sym_go[0] && seen_q |-> idle_q > {1'b0, need_w};
	endproperty
	a_idle_rd: assert property (p_idle_rd)
		else $error("rdata set without read");
	a_rsv_rd: assert property (p_rsv_rd)
		else $error("reserved bits set");
	a_ls_rd: assert property (p_ls_rd)
		else $error("link status reserved bits set");
	a_ps_rd: assert property (p_ps_rd)
		else $error("proc link reserved bits set");
	a_en: assert property (p_en)
		else $error("link enable wrong");
	a_link_greeting_token: assert property (p_link_greeting_token)
		else $error("greeting pulse wrong");
	a_rxr: assert property (p_rxr)
		else $error("receiver reset pulse wrong");
	a_gap: assert property (p_gap)
		else $error("symbol gap too short");
	c_link_greeting_token: cover property (link_greeting_token_send[0]);
	c_go: cover property (sym_go[0] && seen_q);
	c_rxr: cover property (rx_reset[0]);
endmodule

// ---- test/link_far_end.sv ----
// link_far_end: remote link end, answers greetings with credit.
// assumes: link_greeting_token_send pulses on mclk; faults commanded by the bench.
`timescale 1ns/1ps
module link_far_end (
	input wire logic mclk, // system clock
	input wire logic rst, // sync reset
	input wire logic [8:0] link_greeting_token_send, // greeting from our end
	input wire logic slow, // answer late
	input wire logic [8:0] err_cmd, // fault wanted
	output logic [8:0] credit_in_pin, // credit to our end
	output logic [8:0] rx_err_pin // fault on our receiver
);
	logic [5:0] wait_q [9];
	// ----
	// credit answer
	// ----
	always_ff @(posedge mclk) begin
		for (int i = 0; i < 9; i++) begin
			if (rst) begin
				wait_q[i] <= 6'h00;
			end else if (link_greeting_token_send[i]) begin
				wait_q[i] <= slow ? 6'h28 : 6'h0c;
			end else if (wait_q[i] != 6'h00) begin
				wait_q[i] <= wait_q[i] - 6'h01;
			end
		end
	end
	// credit only after a greeting, held long enough to be synced
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			credit_in_pin[i] = wait_q[i] inside {[6'h01:6'h04]};
		end
	end
	assign rx_err_pin = err_cmd;
endmodule

// ---- test/switch_link_config_status_tb_top.sv ----
// switch_link_config_status_tb_top: self-checking bench with far end.
// assumes: package and design compiled first; checker bound below.
`timescale 1ns/1ps
module switch_link_config_status_tb_top;
	logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic pkt_valid = 1'b0, slow = 1'b0, rd_seen = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rnd = 32'h2036aec0, e, rdata;
	logic [1:0] global_debug_event = 2'h0;
	logic [15:0] pkt_mismatch = 16'h0;
	logic [8:0] credit_out = 9'h0, sym_req = 9'h0, sym_last = 9'h0;
	logic [8:0] err_cmd = 9'h0, rx_err_pin, credit_in_pin, link_en;
	logic [8:0] link_wide, sym_go, link_greeting_token_send, rx_reset, route_hit;
	logic [6:0] fexp [8];
	logic [31:0] exp_q [$], msk_q [$];
	int bad_count = 0, checks = 0, cyc = 0, npulse = 0;
	link_cfg_pkg::link_state_t lstate [link_cfg_pkg::n_links];
	link_cfg_pkg::link_state_t pstate [link_cfg_pkg::n_plinks];
	link_cfg_pkg::static_fwd_t fwd [link_cfg_pkg::n_static];
	switch_link_config_status dut_u (.mclk(mclk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.global_debug_event(global_debug_event), .lstate(lstate),
		.pstate(pstate), .rx_err_pin(rx_err_pin),
		.credit_in_pin(credit_in_pin), .credit_out(credit_out),
		.sym_req(sym_req), .sym_last(sym_last), .pkt_mismatch(pkt_mismatch),
		.pkt_valid(pkt_valid), .link_en(link_en), .link_wide(link_wide),
		.sym_go(sym_go), .link_greeting_token_send(link_greeting_token_send), .rx_reset(rx_reset),
		.route_hit(route_hit), .fwd(fwd));
	link_far_end far_u (.mclk(mclk), .rst(rst), .link_greeting_token_send(link_greeting_token_send),
		.slow(slow), .err_cmd(err_cmd), .credit_in_pin(credit_in_pin),
		.rx_err_pin(rx_err_pin));
	// ----
	// bus, checks, report
	// ----
	function automatic logic [31:0] nxt();
		rnd = {rnd[30:0], ^(rnd & 32'h8020_0003)};
		return rnd;
	endfunction
	function automatic logic [31:0] st(input link_cfg_pkg::link_state_t s);
		return {6'h00, s.kind, s.dest, 13'h0000, s.junk, s.dst_busy, s.src_busy};
	endfunction
	task automatic cmp_out(input logic [31:0] got, input logic [31:0] ex);
		checks = checks + 1;
		if (got !== ex) begin
			bad_count = bad_count + 1;
			$display("Error t=%0t got=%h exp=%h", $time, got, ex);
		end
	endtask
	task automatic cmp_rd(input logic [31:0] got, ex, m);
		cmp_out(got & m, ex);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] ex, m);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		exp_q.push_back(ex & m);
		msk_q.push_back(m);
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge mclk);
			wr <= 1'b0;
			rd <= 1'b0;
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) rd_seen <= rd && !rst;
	always @(negedge mclk) begin
		if (rd_seen) begin
			cmp_rd(rdata, exp_q.pop_front(), msk_q.pop_front());
		end
	end
	always @(posedge mclk) begin
		if (sym_go[0] === 1'b1) begin
			npulse = npulse + 1;
		end
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count = bad_count + 1;
			finish_test();
		end
	end
	// ----
	// stimulus
	// ----
	initial begin
		for (int i = 0; i < 9; i++) begin
			lstate[i] = '0;
			pstate[i % 8] = '0;
		end
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		rd_reg(8'h10, 32'h0, 32'hffff_ffff);
		rd_reg(8'h20, 32'h0, 32'hffff_ffff);
		rd_reg(8'h80, 32'h0, 32'h463f_ffff);
		rd_reg(8'ha0, 32'h0, 32'hffff_ffff);
		rd_reg(8'h30, 32'h0, 32'hffff_ffff);
		wr_reg(8'h10, 32'hffff_ffff);
		wr_reg(8'h11, 32'hffff_ffff);
		rd_reg(8'h10, 32'h3, 32'hffff_ffff);
		rd_reg(8'h11, 32'h3, 32'hffff_ffff);
		for (int k = 1; k < 3; k++) begin
			idle(1);
			global_debug_event <= k[1:0];
			idle(1);
			global_debug_event <= 2'h0;
			rd_reg(8'h1f, {30'h0, k[1:0]}, 32'h3);
		end
		wr_reg(8'h1f, 32'hffff_ffff);
		rd_reg(8'h1f, 32'h13, 32'hffff_ffff);
		for (int i = 0; i < 9; i++) begin
			e = nxt();
			lstate[i] <= link_cfg_pkg::link_state_t'(e[12:0]);
			pstate[i % 8] <= link_cfg_pkg::link_state_t'(e[25:13]);
			e = nxt();
			e[11:8] = i[3:0];
			wr_reg(8'h20 + i[7:0], e);
			wr_reg(8'h40 + i[7:0], e);
			rd_reg(8'h20 + i[7:0], st(lstate[i]) | (e & 32'h0f30),
				32'hffff_ffff);
			rd_reg(8'h40 + i[7:0], i < 8 ? st(pstate[i % 8]) | (e & 32'h30)
				: 32'h0, 32'hffff_ffff);
		end
		for (int d = 0; d < 9; d++) begin
			e = nxt();
			idle(1);
			pkt_valid <= 1'b1;
			pkt_mismatch <= (16'h1 << d) | (e[15:0] & ((16'h1 << d) - 16'h1));
			idle(3);
			pkt_valid <= 1'b0;
			@(negedge mclk);
			cmp_out({23'h0, route_hit}, 32'h1 << d);
		end
		for (int k = 0; k < 8; k++) begin
			e = nxt();
			wr_reg(8'ha0 + k[7:0], e);
			rd_reg(8'ha0 + k[7:0], e & 32'h8000_011f, 32'hffff_ffff);
			fexp[k ^ 2] = {e[31], e[8], e[4:0]};
		end
		idle(3);
		@(negedge mclk);
		for (int j = 0; j < 8; j++) begin
			cmp_out({25'h0, fwd[j]}, {25'h0, fexp[j]});
		end
		wr_reg(8'h80, 32'h8000_1005);
		idle(3);
		@(negedge mclk);
		cmp_out({23'h0, link_en}, 32'h1);
		cmp_out({23'h0, link_wide}, 32'h0);
		rd_reg(8'h80, 32'h8000_1005, 32'hfe7f_ffff);
		sym_req <= 9'h001;
		idle(20);
		cmp_out(npulse, 32'h0);
		sym_req <= 9'h000;
		wr_reg(8'h80, 32'hc100_1005);
		idle(25);
		rd_reg(8'h80, 32'h0200_0000, 32'h0200_0000);
		sym_req <= 9'h001;
		@(negedge mclk);
		cmp_out({23'h0, link_wide}, 32'h1);
		repeat (40) begin
			idle(1);
			e = nxt();
			sym_last <= {8'h00, e[0]};
		end
		sym_req <= 9'h000;
		cmp_out(npulse > 3 && npulse <= 14, 32'h1);
		slow <= 1'b1;
		wr_reg(8'h80, 32'hc100_1005);
		idle(4);
		rd_reg(8'h80, 32'h0, 32'h0200_0000);
		idle(50);
		rd_reg(8'h80, 32'h0200_0000, 32'h0200_0000);
		credit_out <= 9'h001;
		idle(3);
		rd_reg(8'h80, 32'h0400_0000, 32'h0400_0000);
		err_cmd <= 9'h001;
		idle(4);
		err_cmd <= 9'h000;
		idle(4);
		rd_reg(8'h80, 32'h0800_0000, 32'h0800_0000);
		wr_reg(8'h80, 32'hc080_1005);
		idle(2);
		rd_reg(8'h80, 32'h0, 32'h0800_0000);
		wr_reg(8'h80, 32'h0000_1005);
		credit_out <= 9'h000;
		idle(3);
		@(negedge mclk);
		cmp_out({23'h0, link_en}, 32'h0);
		idle(1);
		rst <= 1'b1;
		idle(3);
		rst <= 1'b0;
		rd_reg(8'h80, 32'h0, 32'h463f_ffff);
		rd_reg(8'h20, 32'h0, 32'h0000_0f30);
		rd_reg(8'h10, 32'h0, 32'h0000_0003);
		rd_reg(8'h1f, 32'h0, 32'h0000_0013);
		rd_reg(8'ha2, 32'h0, 32'h8000_011f);
		idle(3);
		@(negedge mclk);
		cmp_out({23'h0, link_en | link_wide}, 32'h0);
		idle(2);
		finish_test();
	end
endmodule
bind switch_link_config_status link_cfg_checker chk_u (.mclk(mclk),
	.rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.link_en(link_en), .sym_go(sym_go), .sym_last(sym_last),
	.link_greeting_token_send(link_greeting_token_send), .rx_reset(rx_reset));
